// ==== hdl/pcfg_decoder.sv ====
// Serial configuration command decoder with parameter storage
`timescale 1ns/1ns
module pcfg_decoder #(
   parameter int OTP_CYCLES_P = pcfg_pkg::OTP_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_sclk,
   input  wire logic        spi_dc,
   input  wire logic        spi_sda_i,
   output logic             spi_sda_o,
   output logic             spi_sda_oe,
   output logic             busy,
   output logic [8:0]       gate_line_count,
   output logic             first_gate_select,
   output logic             gate_interleave_select,
   output logic [4:0]       gate_high_level,
   output logic             gate_level_invalid,
   output logic [7:0]       source_high_level_a,
   output logic [7:0]       source_high_level_b,
   output logic [7:0]       source_low_level,
   output logic             source_low_invalid,
   output logic [31:0]      initial_code_setting,
   output logic [31:0]      booster_softstart,
   output logic [2:0]       boost_invalid,
   output logic [1:0]       sleep_select,
   output logic             otp_program_pulse
);
   import pcfg_pkg::*;

   // Two-stage synchronisers for all pins
   logic [1:0] cs_s_q;
   logic [1:0] sclk_s_q;
   logic [1:0] dc_s_q;
   logic [1:0] sda_s_q;
   logic       sclk_old_q;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cs_s_q     <= 2'b11;
         sclk_s_q   <= 2'b00;
         dc_s_q     <= 2'b00;
         sda_s_q    <= 2'b00;
         sclk_old_q <= 1'b0;
      end else begin
         cs_s_q     <= {cs_s_q[0], spi_cs_n};
         sclk_s_q   <= {sclk_s_q[0], spi_sclk};
         dc_s_q     <= {dc_s_q[0], spi_dc};
         sda_s_q    <= {sda_s_q[0], spi_sda_i};
         sclk_old_q <= sclk_s_q[1];
      end
   end

   logic sel;
   logic rise;
   logic fall;
   assign sel  = ~cs_s_q[1];
   assign rise = sel & sclk_s_q[1] & ~sclk_old_q;
   assign fall = sel & ~sclk_s_q[1] & sclk_old_q;

   // Byte assembly, MSB first
   logic [6:0] shift_q;
   logic [2:0] bit_cnt_q;
   logic       byte_stb_q;
   logic [7:0] byte_q;
   logic       byte_dc_q;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_q    <= 7'h00;
         bit_cnt_q  <= 3'h0;
         byte_stb_q <= 1'b0;
         byte_q     <= 8'h00;
         byte_dc_q  <= 1'b0;
      end else begin
         byte_stb_q <= 1'b0;
         if (!sel) begin
            bit_cnt_q <= 3'h0;
         end else if (rise) begin
            shift_q   <= {shift_q[5:0], sda_s_q[1]};
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
               byte_q     <= {shift_q, sda_s_q[1]};
               byte_dc_q  <= dc_s_q[1];
               byte_stb_q <= 1'b1;
            end
         end
      end
   end

   // Command sequencing
   pcfg_state_t state_q;
   logic [7:0]  cmd_q;
   logic [2:0]  idx_q;
   logic [2:0]  npar;
   logic [$clog2(OTP_CYCLES_P+1)-1:0] otp_cnt_q;
   logic        known;

   always_comb begin
      unique case (byte_q)
         CMD_GATE_SCAN:     npar = NPAR_GATE_SCAN;
         CMD_GATE_LEVEL:    npar = NPAR_GATE_LEVEL;
         CMD_SOURCE_LEVELS: npar = NPAR_SOURCE;
         CMD_INIT_CODE_WR:  npar = NPAR_INIT_CODE;
         CMD_BOOSTER:       npar = NPAR_BOOSTER;
         CMD_SLEEP:         npar = NPAR_SLEEP;
         default:           npar = 3'h0;
      endcase
   end

   // Every command with parameters is known; zero count means not ours
   assign known = (npar != 3'h0);

   logic par_stb;
   assign par_stb = byte_stb_q & byte_dc_q & (state_q == PCFG_PARAM);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q           <= PCFG_IDLE;
         cmd_q             <= 8'h00;
         idx_q             <= 3'h0;
         otp_cnt_q         <= '0;
         busy              <= 1'b0;
         otp_program_pulse <= 1'b0;
      end else begin
         otp_program_pulse <= 1'b0;
         unique case (state_q)
            PCFG_IDLE, PCFG_PARAM: begin
               if (byte_stb_q && !byte_dc_q) begin
                  cmd_q <= byte_q;
                  idx_q <= 3'h0;
                  if (byte_q == CMD_OTP_PROGRAM) begin
                     state_q           <= PCFG_OTP;
                     busy              <= 1'b1;
                     otp_program_pulse <= 1'b1;
                     otp_cnt_q         <= '0;
                  end else if (known) begin
                     state_q <= PCFG_PARAM;
                  end else begin
                     state_q <= PCFG_IDLE;
                  end
               end else if (par_stb) begin
                  idx_q <= idx_q + 3'h1;
                  if (idx_q + 3'h1 == npar_of(cmd_q)) begin
                     state_q <= PCFG_IDLE;
                  end
               end
            end
            PCFG_OTP: begin
               // Bytes are dropped here, so nothing disturbs programming
               otp_cnt_q <= otp_cnt_q + 1'b1;
               if (otp_cnt_q == OTP_CYCLES_P[$bits(otp_cnt_q)-1:0] - 1'b1) begin
                  busy    <= 1'b0;
                  state_q <= PCFG_IDLE;
               end
            end
         endcase
      end
   end

   function automatic logic [2:0] npar_of(input logic [7:0] c);
      unique case (c)
         CMD_GATE_SCAN:     npar_of = NPAR_GATE_SCAN;
         CMD_GATE_LEVEL:    npar_of = NPAR_GATE_LEVEL;
         CMD_SOURCE_LEVELS: npar_of = NPAR_SOURCE;
         CMD_INIT_CODE_WR:  npar_of = NPAR_INIT_CODE;
         CMD_BOOSTER:       npar_of = NPAR_BOOSTER;
         CMD_SLEEP:         npar_of = NPAR_SLEEP;
         default:           npar_of = 3'h0;
      endcase
   endfunction

   // Parameter storage
   logic [23:0] gate_scan_setup_q;
   logic [23:0] source_levels_q;
   logic [7:0]  gate_level_q;
   logic [7:0]  sleep_q;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gate_scan_setup_q    <= GATE_SCAN_RST;
         gate_level_q         <= GATE_LEVEL_RST;
         source_levels_q      <= SOURCE_RST;
         initial_code_setting <= INIT_CODE_RST;
         booster_softstart    <= BOOSTER_RST;
         sleep_q              <= SLEEP_RST;
      end else if (par_stb) begin
         unique case (cmd_q)
            CMD_GATE_SCAN:
               gate_scan_setup_q[8'(23 - 8*idx_q) -: 8] <= byte_q;
            CMD_GATE_LEVEL:
               gate_level_q <= byte_q;
            CMD_SOURCE_LEVELS:
               source_levels_q[8'(23 - 8*idx_q) -: 8] <= byte_q;
            CMD_INIT_CODE_WR:
               initial_code_setting[8'(31 - 8*idx_q) -: 8] <= byte_q;
            CMD_BOOSTER:
               booster_softstart[8'(31 - 8*idx_q) -: 8] <= byte_q;
            CMD_SLEEP: begin
               // Once asleep only reset wakes the device
               if (sleep_q[1:0] == SLEEP_NORMAL) begin
                  sleep_q <= byte_q;
               end
            end
            default: ;
         endcase
      end
   end

   // Decoded outputs, registered; they trail the stored bytes by one cycle
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gate_line_count        <= 9'h000;
         first_gate_select      <= 1'b0;
         gate_interleave_select <= 1'b0;
      end else begin
         // Count is programmed value plus one
         gate_line_count <= {gate_scan_setup_q[8], gate_scan_setup_q[23:16]}
                            + 9'h001;
         first_gate_select      <= gate_scan_setup_q[2];
         gate_interleave_select <= gate_scan_setup_q[1];
      end
   end

   // Level and its flag leave in the same cycle so a reader never mixes them
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gate_high_level    <= GATE_LEVEL_RST[4:0];
         gate_level_invalid <= 1'b0;
      end else begin
         gate_high_level    <= gate_level_q[4:0];
         gate_level_invalid <= !((gate_level_q[4:0] == GATE_CODE_ALT20) ||
                                 (gate_level_q[4:0] >= GATE_CODE_MIN &&
                                  gate_level_q[4:0] <= GATE_CODE_MAX));
      end
   end

   // Reset shows the stored defaults, which are valid, so the flag stays low
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         source_high_level_a <= SOURCE_RST[23:16];
         source_high_level_b <= SOURCE_RST[15:8];
         source_low_level    <= SOURCE_RST[7:0];
         source_low_invalid  <= 1'b0;
      end else begin
         source_high_level_a <= source_levels_q[23:16];
         source_high_level_b <= source_levels_q[15:8];
         source_low_level    <= source_levels_q[7:0];
         source_low_invalid  <= source_levels_q[7] || source_levels_q[0] ||
                                source_levels_q[6:0] < SRC_LOW_MIN ||
                                source_levels_q[6:0] > SRC_LOW_MAX;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sleep_select <= SLEEP_NORMAL;
      end else begin
         sleep_select <= sleep_q[1:0];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_boost
         always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
               boost_invalid[gi] <= 1'b0;
            end else begin
               boost_invalid[gi] <= booster_softstart[8*(3-gi)+3 -: 4]
                                    < BOOST_OFF_MIN;
            end
         end
      end
   endgenerate

   // Read-back of the initial-code register, shifted on falling edges
   logic [31:0] rd_sr_q;
   logic        rd_act_q;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_sr_q    <= 32'h0000_0000;
         rd_act_q   <= 1'b0;
         spi_sda_o  <= 1'b0;
         spi_sda_oe <= 1'b0;
      end else if (!sel) begin
         rd_act_q   <= 1'b0;
         spi_sda_oe <= 1'b0;
      end else if (byte_stb_q && !byte_dc_q) begin
         rd_act_q <= (byte_q == CMD_INIT_CODE_RD) && (state_q != PCFG_OTP);
         rd_sr_q  <= initial_code_setting;
      end else if (rd_act_q && fall && dc_s_q[1]) begin
         spi_sda_o  <= rd_sr_q[31];
         spi_sda_oe <= 1'b1;
         rd_sr_q    <= {rd_sr_q[30:0], 1'b0};
      end
   end
endmodule // pcfg_decoder

// ==== shared/pcfg_pkg.sv ====
// Constants for the panel configuration command decoder
package pcfg_pkg;
   localparam logic [7:0] CMD_GATE_SCAN      = 8'h01;
   localparam logic [7:0] CMD_GATE_LEVEL     = 8'h03;
   localparam logic [7:0] CMD_SOURCE_LEVELS  = 8'h04;
   localparam logic [7:0] CMD_OTP_PROGRAM    = 8'h08;
   localparam logic [7:0] CMD_INIT_CODE_WR   = 8'h09;
   localparam logic [7:0] CMD_INIT_CODE_RD   = 8'h0A;
   localparam logic [7:0] CMD_BOOSTER        = 8'h0C;
   localparam logic [7:0] CMD_SLEEP          = 8'h10;

   localparam logic [2:0] NPAR_GATE_SCAN     = 3'h3;
   localparam logic [2:0] NPAR_GATE_LEVEL    = 3'h1;
   localparam logic [2:0] NPAR_SOURCE        = 3'h3;
   localparam logic [2:0] NPAR_INIT_CODE     = 3'h4;
   localparam logic [2:0] NPAR_BOOSTER       = 3'h4;
   localparam logic [2:0] NPAR_SLEEP         = 3'h1;

   localparam logic [23:0] GATE_SCAN_RST     = 24'h00_0000;
   localparam logic [7:0]  GATE_LEVEL_RST    = 8'h00;
   localparam logic [23:0] SOURCE_RST        = 24'h41_A832;
   localparam logic [31:0] INIT_CODE_RST     = 32'h0000_0000;
   localparam logic [31:0] BOOSTER_RST       = 32'h8B9C_960F;
   localparam logic [7:0]  SLEEP_RST         = 8'h00;

   localparam logic [4:0] GATE_CODE_ALT20    = 5'h00;
   localparam logic [4:0] GATE_CODE_MIN      = 5'h03;
   localparam logic [4:0] GATE_CODE_MAX      = 5'h17;
   localparam logic [6:0] SRC_LOW_MIN        = 7'h0A;
   localparam logic [6:0] SRC_LOW_MAX        = 7'h3A;
   localparam logic [3:0] BOOST_OFF_MIN      = 4'h4;

   localparam logic [1:0] SLEEP_NORMAL       = 2'h0;
   localparam logic [1:0] SLEEP_MODE1        = 2'h1;
   localparam logic [1:0] SLEEP_MODE2        = 2'h3;

   localparam int OTP_TIME_US = 100;
   localparam int CLK_MHZ     = 100;
   localparam int OTP_CYCLES  = OTP_TIME_US * CLK_MHZ;

   typedef enum logic [1:0] {PCFG_IDLE, PCFG_PARAM, PCFG_OTP} pcfg_state_t;
endpackage

// ==== testbench/pcfg_decoder_asserts.sv ====
// Port-level checks for the configuration command decoder
`timescale 1ns/1ns
module pcfg_decoder_asserts #(
   parameter int OTP_CYCLES_P = 20
) (
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        spi_cs_n,
   input wire logic        spi_sda_oe,
   input wire logic        busy,
   input wire logic        otp_program_pulse,
   input wire logic [4:0]  gate_high_level,
   input wire logic        gate_level_invalid,
   input wire logic [7:0]  source_low_level,
   input wire logic        source_low_invalid,
   input wire logic [31:0] booster_softstart,
   input wire logic [2:0]  boost_invalid,
   input wire logic [31:0] initial_code_setting,
   input wire logic [1:0]  sleep_select
);
   logic [15:0] busy_cnt_q;
   logic        gate_bad;
   logic        src_bad;
   logic [2:0]  boost_bad;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   assign gate_bad = !(gate_high_level == 5'h00 ||
                       (gate_high_level >= 5'h03 && gate_high_level <= 5'h17));
   assign src_bad = source_low_level[7] || source_low_level[0] || source_low_level[6:0] < 7'h0A ||
                    source_low_level[6:0] > 7'h3A;
   assign boost_bad = {booster_softstart[11:8] < 4'h4, booster_softstart[19:16] < 4'h4,
                       booster_softstart[27:24] < 4'h4};
   // Length of the current busy span
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst)
         busy_cnt_q <= 16'h0000;
      else if (busy)
         busy_cnt_q <= busy_cnt_q + 16'h0001;
      else
         busy_cnt_q <= 16'h0000;
   end
   AST_BUSY_SPAN: assert property ($fell(busy) |-> busy_cnt_q == 16'(OTP_CYCLES_P))
      else $error("busy span length wrong");
   AST_OTP_BUSY: assert property (otp_program_pulse |-> ##[0:2] busy)
      else $error("programming did not raise busy");
   AST_GATE_CODE: assert property (1'b1 |-> gate_level_invalid == gate_bad)
      else $error("gate code validity wrong");
   AST_SRC_LOW: assert property (1'b1 |-> source_low_invalid == src_bad)
      else $error("source low validity wrong");
   AST_BOOST_OFF: assert property (1'b1 |=> boost_invalid == $past(boost_bad))
      else $error("booster off time validity wrong");
   AST_READ_IDLE: assert property (spi_cs_n [*5] |-> !spi_sda_oe)
      else $error("data line driven while deselected");
   AST_BUSY_FREEZE: assert property (busy |=> $stable(initial_code_setting) &&
                                     $stable(gate_high_level))
      else $error("setting changed while busy");
   AST_SLEEP_STAYS: assert property (sleep_select != 2'h0 |=> $stable(sleep_select))
      else $error("left deep sleep without reset");
endmodule // pcfg_decoder_asserts

bind pcfg_decoder pcfg_decoder_asserts #(.OTP_CYCLES_P(OTP_CYCLES_P)) chk (
   .ref_clk, .sys_rst, .spi_cs_n, .spi_sda_oe, .busy, .otp_program_pulse, .gate_high_level,
   .gate_level_invalid, .source_low_level, .source_low_invalid, .booster_softstart,
   .boost_invalid, .initial_code_setting, .sleep_select);

// ==== testbench/pcfg_host_model.sv ====
// Host microcontroller model driving the serial command port
`timescale 1ns/1ns
module pcfg_host_model (
   input  wire logic sda_w,
   output logic      cs_n,
   output logic      sclk,
   output logic      dc,
   output logic      sda
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      dc   = 1'b0;
      sda  = 1'b0;
   end
   // Code byte then np parameter bytes; rd keeps the last 32 bits seen
   task automatic frame(input logic [7:0] c, input logic [31:0] p, input int np,
                        output logic [31:0] rd);
      logic [39:0] sh;
      sh = {c, p << (8 * (4 - np))};
      rd = 32'h0000_0000;
      cs_n = 1'b0;
      // Offset keeps pin changes off the sampling clock edge in frames starting 0, 2 or 4 ns after a negedge, not 6 or 8; each frame adds 2 ns
      #62;
      for (int i = 0; i < 8 * (np + 1); i++) begin
         sclk = 1'b0;
         dc   = (i >= 8);
         sda  = sh[39 - i];
         #62;
         sclk = 1'b1;
         rd   = {rd[30:0], sda_w};
         #63;
      end
      sclk = 1'b0;
      #70;
      cs_n = 1'b1;
      // Released line flips so a stale bit cannot pass for data
      sda  = ~sda;
      #250;
   endtask
endmodule // pcfg_host_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the configuration command decoder
`timescale 1ns/1ns
module testbench;
   import pcfg_pkg::*;
   localparam int OTP_N = 400;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   wire logic   cs_n, sclk, dc, h_sda;
   logic        sda_o, sda_oe, busy, fgs, gis, gli, sli, opp;
   logic [8:0]  glc;
   logic [4:0]  ghl;
   logic [7:0]  sa, sb, sl;
   logic [31:0] ics, bss, rd;
   logic [2:0]  bi;
   logic [1:0]  ss;
   int          checks = 0;
   int          err_total = 0;
   int          bw = 0;
   int          bw_last = 0;
   wire logic   sda_w = sda_oe ? sda_o : h_sda;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (busy)
         bw <= bw + 1;
      else if (bw != 0) begin
         bw_last <= bw;
         bw <= 0;
      end
   end
   pcfg_host_model host (.sda_w(sda_w), .cs_n(cs_n), .sclk(sclk), .dc(dc), .sda(h_sda));
   pcfg_decoder #(.OTP_CYCLES_P(OTP_N)) uut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_dc(dc),
      .spi_sda_i(sda_w), .spi_sda_o(sda_o), .spi_sda_oe(sda_oe), .busy(busy),
      .gate_line_count(glc), .first_gate_select(fgs), .gate_interleave_select(gis),
      .gate_high_level(ghl), .gate_level_invalid(gli), .source_high_level_a(sa),
      .source_high_level_b(sb), .source_low_level(sl), .source_low_invalid(sli),
      .initial_code_setting(ics), .booster_softstart(bss), .boost_invalid(bi),
      .sleep_select(ss), .otp_program_pulse(opp));
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic rst;
      @(negedge ref_clk) sys_rst = 1'b1;
      repeat (12) @(negedge ref_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask
   task automatic t_reset;
      chk("src", {sa, sb, sl}, 24'h41_A832);
      chk("boost", bss, 32'h8B9C_960F);
      chk("lines", glc, 9'h001);
      chk("sleep", ss, 2'h0);
      host.frame(8'h7E, 32'h0000_0017, 1, rd);
      chk("orphan", ghl, 5'h00);
   endtask
   task automatic t_gate;
      host.frame(CMD_GATE_SCAN, 32'h002B_0106, 3, rd);
      chk("lines", glc, 9'h12C);
      chk("order", {fgs, gis}, 2'b11);
      // Fourth byte would land as a new first byte if the count wrapped
      host.frame(CMD_GATE_SCAN, 32'h0700_00FF, 4, rd);
      chk("lines", glc, 9'h008);
      chk("order", {fgs, gis}, 2'b00);
   endtask
   task automatic t_level;
      logic [29:0] codes = {5'h1F, 5'h01, 5'h18, 5'h17, 5'h03, 5'h00};
      logic [5:0]  bad = 6'b111000;
      for (int i = 0; i < 6; i++) begin
         host.frame(CMD_GATE_LEVEL, {27'h0, codes[5*i +: 5]}, 1, rd);
         chk("gate", ghl, codes[5*i +: 5]);
         chk("gate bad", gli, bad[i]);
      end
   endtask
   task automatic t_source;
      logic [31:0] codes = 32'h3A0B_3C08;
      logic [3:0]  bad = 4'b1110;
      for (int i = 0; i < 4; i++) begin
         host.frame(CMD_SOURCE_LEVELS, {16'h4A3C, codes[31-8*i -: 8]}, 3, rd);
         chk("src", {sa, sb, sl}, {16'h4A3C, codes[31-8*i -: 8]});
         chk("src bad", sli, bad[i]);
      end
   endtask
   task automatic t_boost;
      host.frame(CMD_BOOSTER, 32'hF394_AF39, 4, rd);
      chk("boost", bss, 32'hF394_AF39);
      chk("boost bad", bi, 3'b001);
   endtask
   task automatic t_init;
      host.frame(CMD_INIT_CODE_WR, 32'hDEAD_BEEF, 4, rd);
      chk("init", ics, 32'hDEAD_BEEF);
      host.frame(CMD_INIT_CODE_RD, 32'h0000_0000, 4, rd);
      chk("readback", rd, 32'hDEAD_BEEF);
      chk("released", sda_oe, 1'b0);
   endtask
   task automatic t_otp;
      host.frame(CMD_GATE_LEVEL, 32'h0000_0005, 1, rd);
      host.frame(CMD_OTP_PROGRAM, 32'h0000_0000, 0, rd);
      host.frame(CMD_GATE_LEVEL, 32'h0000_0017, 1, rd);
      chk("busy", busy, 1'b1);
      for (int i = 0; i < 1000 && busy !== 1'b0; i++)
         @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
      chk("gate", ghl, 5'h05);
      chk("busy span", bw_last, OTP_N);
   endtask
   task automatic t_sleep;
      host.frame(CMD_SLEEP, 32'h0000_0001, 1, rd);
      chk("sleep", ss, 2'h1);
      host.frame(CMD_SLEEP, 32'h0000_0000, 1, rd);
      chk("sleep", ss, 2'h1);
      rst;
      chk("sleep", ss, 2'h0);
      host.frame(CMD_SLEEP, 32'h0000_0003, 1, rd);
      chk("sleep", ss, 2'h3);
      rst;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      rst;
      t_reset;
      t_gate;
      t_level;
      t_source;
      t_boost;
      t_init;
      t_otp;
      t_sleep;
      print_verdict;
   end
   // 22 frames of a few microseconds each
   initial begin
      #500000;
      err_total++;
      print_verdict;
   end
endmodule // testbench
